// [rtl/mapf_top.sv]
// Auxiliary pads, transmit monitor, alarm, tone and status lamp
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "mapf_consts.svh"
module mapf_top #(
  parameter int unsigned LEAD_CYC     = `MAPF_LEAD_MS * `MAPF_CLK_KHZ,
  parameter int unsigned TAIL_CYC     = `MAPF_TAIL_MS * `MAPF_CLK_KHZ,
  parameter int unsigned FAST_PER_CYC = `MAPF_FAST_PER_MS * `MAPF_CLK_KHZ,
  parameter int unsigned FAST_ON_CYC  = `MAPF_FAST_ON_MS * `MAPF_CLK_KHZ,
  parameter int unsigned SLOW_PER_CYC = `MAPF_SLOW_PER_MS * `MAPF_CLK_KHZ,
  parameter int unsigned SLOW_ON_CYC  = `MAPF_SLOW_ON_MS * `MAPF_CLK_KHZ
) (
  input  wire logic                    mclk,            // Module clock
  input  wire logic                    rst,             // Async reset
  input  wire mapf_pkg::mapf_apb_req_s apb_req,         // APB request
  output logic [31:0]                  prdata,          // APB read data
  output logic                         pready,          // APB ready
  output logic                         pslverr,         // APB error
  input  wire logic [3:0]              pad_in,          // Pad levels
  output logic [3:0]                   pad_out,         // Pad drive value
  output logic [3:0]                   pad_oe,          // Pad drive enable
  input  wire logic                    tx_burst,        // Radio burst request
  input  wire logic                    call_active,     // Call in progress
  input  wire logic                    dev_on,          // Device powered
  input  wire logic                    net_registered,  // Full service
  input  wire logic                    shutting_down,   // Turning off
  input  wire logic                    alarm_fire,      // Alarm pulse
  input  wire logic                    tone_on,         // Tone request
  output logic                         tx_enable,       // Transmitter allowed
  output logic                         status_lamp_pin, // Lamp drive, low lit
  output logic                         irq              // Interrupt level
);
  import mapf_pkg::*;

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic [7:0]  mode_reg;
  logic [3:0]  out_reg;
  logic [3:0]  in_reg;
  logic        mon_burst_reg;
  logic [15:0] tone_div_reg;
  logic [2:0]  ists_reg;
  logic [2:0]  imsk_reg;
  logic        alarm_reg;
  logic        tx_act_mon_reg;
  mapf_lamp_e  lamp_reg;
  logic        setup;
  logic        wr_ok;
  logic        alarm_clr;
  logic [2:0]  ev;

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `MAPF_OFS_MODE, `MAPF_OFS_OUT, `MAPF_OFS_IN, `MAPF_OFS_MON,
      `MAPF_OFS_TONE, `MAPF_OFS_CMD, `MAPF_OFS_ISTS, `MAPF_OFS_IMSK,
      `MAPF_OFS_STAT: addr_ok = 1'b1;
      default:        addr_ok = 1'b0;
    endcase
  endfunction

  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_ok = apb_req.psel & apb_req.penable & apb_req.pwrite & pready & ~pslverr;
  assign alarm_clr = wr_ok & (apb_req.paddr == `MAPF_OFS_CMD) & apb_req.pwdata[0];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_ok(apb_req.paddr);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (setup & ~apb_req.pwrite) begin
      case (apb_req.paddr)
        `MAPF_OFS_MODE: prdata <= {24'h000000, mode_reg};
        `MAPF_OFS_OUT:  prdata <= {28'h0000000, out_reg};
        `MAPF_OFS_IN:   prdata <= {28'h0000000, in_reg};
        `MAPF_OFS_MON:  prdata <= {31'h00000000, mon_burst_reg};
        `MAPF_OFS_TONE: prdata <= {16'h0000, tone_div_reg};
        `MAPF_OFS_ISTS: prdata <= {29'h00000000, ists_reg};
        `MAPF_OFS_IMSK: prdata <= {29'h00000000, imsk_reg};
        `MAPF_OFS_STAT: prdata <= {25'h0000000, lamp_reg, tx_enable, tx_act_mon_reg,
                                   alarm_reg};
        default:        prdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_reg      <= `MAPF_RST_MODE;
      out_reg       <= `MAPF_RST_OUT;
      mon_burst_reg <= 1'b0;
      tone_div_reg  <= `MAPF_RST_TONE;
      imsk_reg      <= 3'h0;
    end else if (wr_ok) begin
      case (apb_req.paddr)
        `MAPF_OFS_MODE: mode_reg      <= apb_req.pwdata[7:0];
        `MAPF_OFS_OUT:  out_reg       <= apb_req.pwdata[3:0];
        `MAPF_OFS_MON:  mon_burst_reg <= apb_req.pwdata[0];
        `MAPF_OFS_TONE: tone_div_reg  <= apb_req.pwdata[15:0];
        `MAPF_OFS_IMSK: imsk_reg      <= apb_req.pwdata[2:0];
        default:        mon_burst_reg <= mon_burst_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ists_reg <= 3'h0;
      irq      <= 1'b0;
    end else begin
      if (wr_ok && apb_req.paddr == `MAPF_OFS_ISTS) begin
        ists_reg <= (ists_reg & ~apb_req.pwdata[2:0]) | ev;
      end else begin
        ists_reg <= ists_reg | ev;
      end
      irq <= |(ists_reg & imsk_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Pad muxing
  // ----------------------------------------------------------------------
  logic [3:0] alt_src;
  logic       tone_reg;
  localparam logic [3:0] ALT_IS_OUT = `MAPF_ALT_IS_OUT;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_reg <= 4'h0;
    end else begin
      in_reg <= pad_in;
    end
  end

  assign alt_src = {tone_reg, alarm_reg, tx_act_mon_reg, 1'b0};

  genvar k;
  generate
    for (k = 0; k < `MAPF_NPAD; k++) begin : g_pad
      mapf_mode_t md;
      logic       alt_out;
      assign md = mode_reg[2*k+1:2*k];
      assign alt_out = (md == `MAPF_MODE_ALT) & ALT_IS_OUT[k];
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          pad_oe[k]  <= 1'b0;
          pad_out[k] <= 1'b0;
        end else begin
          pad_oe[k]  <= (md == `MAPF_MODE_OUT) | alt_out;
          pad_out[k] <= (md == `MAPF_MODE_OUT) ? out_reg[k] : (alt_out & alt_src[k]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Transmitter inhibit and monitor
  // ----------------------------------------------------------------------
  logic      inhibit;
  logic      inhibit_q;
  logic      call_q;
  logic      call_rise;
  logic      call_mode;
  logic      mon_next;
  mapf_cnt_t lead_cnt;
  mapf_cnt_t tail_cnt;

  assign inhibit = (mode_reg[1:0] == `MAPF_MODE_ALT) & ~in_reg[`MAPF_PAD_INH];
  assign call_rise = call_active & ~call_q;
  assign call_mode = (mode_reg[3:2] == `MAPF_MODE_ALT) & ~mon_burst_reg;
  assign mon_next = mon_burst_reg ? (tx_burst & tx_enable)
                  : (call_active | (lead_cnt != '0) | (tail_cnt != '0));
  assign ev = {mon_next & ~tx_act_mon_reg, inhibit & ~inhibit_q, alarm_fire};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      call_q    <= 1'b0;
      inhibit_q <= 1'b0;
      tx_enable <= 1'b0;
    end else begin
      call_q    <= call_active;
      inhibit_q <= inhibit;
      // Bursts held back until the lead time has passed
      tx_enable <= ~inhibit & ~(call_mode & (call_rise | (lead_cnt != '0)));
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lead_cnt <= '0;
    end else if (call_rise) begin
      lead_cnt <= mapf_cnt_t'(LEAD_CYC);
    end else if (lead_cnt != '0) begin
      lead_cnt <= lead_cnt - 25'h0000001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tail_cnt <= '0;
    end else if (tx_burst & tx_enable) begin
      tail_cnt <= mapf_cnt_t'(TAIL_CYC);
    end else if (tail_cnt != '0) begin
      tail_cnt <= tail_cnt - 25'h0000001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_act_mon_reg <= 1'b0;
    end else begin
      tx_act_mon_reg <= mon_next;
    end
  end

  // ----------------------------------------------------------------------
  // Alarm
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alarm_reg <= 1'b0;
    end else if (alarm_fire) begin
      alarm_reg <= 1'b1;
    end else if (alarm_clr) begin
      alarm_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Tone square wave, half period of tone_div_reg cycles
  // ----------------------------------------------------------------------
  logic [15:0] tone_cnt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tone_cnt <= 16'h0000;
      tone_reg <= 1'b0;
    end else if (!tone_on || tone_div_reg == 16'h0000) begin
      tone_cnt <= 16'h0000;
      tone_reg <= 1'b0;
    end else if (tone_cnt >= tone_div_reg - 16'h0001) begin
      tone_cnt <= 16'h0000;
      tone_reg <= ~tone_reg;
    end else begin
      tone_cnt <= tone_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Status lamp
  // ----------------------------------------------------------------------
  mapf_lamp_e lamp_next;
  mapf_cnt_t  lamp_cnt;
  logic       lit;

  always_comb begin
    if (!dev_on) begin
      lamp_next = MAPF_LAMP_OFF;
    end else if (call_active) begin
      lamp_next = MAPF_LAMP_ON;
    end else if (net_registered && !shutting_down) begin
      lamp_next = MAPF_LAMP_SLOW;
    end else begin
      lamp_next = MAPF_LAMP_FAST;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lamp_reg <= MAPF_LAMP_OFF;
      lamp_cnt <= '0;
    end else begin
      lamp_reg <= lamp_next;
      if (lamp_next != lamp_reg) begin
        lamp_cnt <= '0;
      end else if ((lamp_reg == MAPF_LAMP_FAST &&
                    lamp_cnt == mapf_cnt_t'(FAST_PER_CYC - 1)) ||
                   (lamp_reg == MAPF_LAMP_SLOW &&
                    lamp_cnt == mapf_cnt_t'(SLOW_PER_CYC - 1))) begin
        lamp_cnt <= '0;
      end else begin
        lamp_cnt <= lamp_cnt + 25'h0000001;
      end
    end
  end

  always_comb begin
    unique case (lamp_reg)
      MAPF_LAMP_OFF:  lit = 1'b0;
      MAPF_LAMP_FAST: lit = lamp_cnt < mapf_cnt_t'(FAST_ON_CYC);
      MAPF_LAMP_SLOW: lit = lamp_cnt < mapf_cnt_t'(SLOW_ON_CYC);
      MAPF_LAMP_ON:   lit = 1'b1;
      default:        lit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_lamp_pin <= 1'b1;
    end else begin
      status_lamp_pin <= ~lit;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_call_start;
    call_active && !call_q && call_mode;
  endsequence
  sequence s_tx_held;
    !tx_enable [*8];
  endsequence

  property p_in_sample;
    1 |=> in_reg == $past(pad_in);
  endproperty
  a_in_sample: assert property (p_in_sample) else $error("input not sampled");
  property p_out_drive;
    mode_reg[7:6] == `MAPF_MODE_OUT |=> pad_oe[3] && pad_out[3] == $past(out_reg[3]);
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("output pad not driven");
  property p_inh_pad;
    mode_reg[1:0] == `MAPF_MODE_IN |=> !pad_oe[0];
  endproperty
  a_inh_pad: assert property (p_inh_pad) else $error("input pad driven");
  property p_inhibit;
    mode_reg[1:0] == `MAPF_MODE_ALT && !pad_in[0] ##1
    mode_reg[1:0] == `MAPF_MODE_ALT |=> !tx_enable;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("transmitter not inhibited");
  property p_lead;
    s_call_start |=> s_tx_held and (tx_act_mon_reg [*8]);
  endproperty
  a_lead: assert property (p_lead) else $error("lead time not kept");
  property p_burst;
    mon_burst_reg && tx_burst && tx_enable |=> tx_act_mon_reg;
  endproperty
  a_burst: assert property (p_burst) else $error("monitor missed a burst");
  property p_alarm_hold;
    alarm_reg && !alarm_clr |=> alarm_reg;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped early");
  property p_alarm_clr;
    alarm_clr && !alarm_fire |=> !alarm_reg;
  endproperty
  a_alarm_clr: assert property (p_alarm_clr) else $error("alarm not cleared");
  property p_lamp_call;
    dev_on && call_active && $stable(call_active) |=> ##1 !status_lamp_pin;
  endproperty
  a_lamp_call: assert property (p_lamp_call) else $error("lamp not on in call");
  property p_lamp_off;
    !dev_on [*2] |=> status_lamp_pin;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp lit while off");
  property p_irq_set;
    alarm_fire |=> ists_reg[`MAPF_IRQ_ALARM];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("alarm event lost");
endmodule

// [rtl/mapf_consts.svh]
// Constants of the auxiliary pad block: offsets, codes, reset values, times
// Summary of operation
// - Pads are input, output or alternate; input at reset
// - Input pads report the sampled external level
// - Output pads drive high and low, push-pull
// - Inhibit pad held low disables the transmitter
// - Monitor pad high while transmitter active
// - Monitor has call-duration and burst-following modes
// - Call mode: high whole call, 300ms lead
// - Call mode: low 500ms to 1s after last burst
// - Burst mode: monitor follows each transmit burst
// - Alarm pad high on alarm until clear command
// - Tone pad outputs square waves for buzzer
// - Lamp pin is inverse of lamp state
// - Lamp off when device off, on in call
// - Searching or unregistered: 1s period, 0,5s lit
// - Registered idle: 3s period, 0,3s lit
`ifndef MAPF_CONSTS_SVH
`define MAPF_CONSTS_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MAPF_OFS_MODE   8'h00
`define MAPF_OFS_OUT    8'h04
`define MAPF_OFS_IN     8'h08
`define MAPF_OFS_MON    8'h0C
`define MAPF_OFS_TONE   8'h10
`define MAPF_OFS_CMD    8'h14
`define MAPF_OFS_ISTS   8'h18
`define MAPF_OFS_IMSK   8'h1C
`define MAPF_OFS_STAT   8'h20
// ----------------------------------------------------------------------
// Pad indices and mode codes
// ----------------------------------------------------------------------
`define MAPF_PAD_INH    0
`define MAPF_PAD_MON    1
`define MAPF_PAD_ALM    2
`define MAPF_PAD_TONE   3
`define MAPF_NPAD       4
`define MAPF_MODE_IN    2'h0
`define MAPF_MODE_OUT   2'h1
`define MAPF_MODE_ALT   2'h2
`define MAPF_ALT_IS_OUT 4'hE
// ----------------------------------------------------------------------
// Reset values and interrupt bits
// ----------------------------------------------------------------------
`define MAPF_RST_MODE   8'h00
`define MAPF_RST_OUT    4'h0
`define MAPF_RST_TONE   16'h0000
`define MAPF_IRQ_ALARM  0
`define MAPF_IRQ_INH    1
`define MAPF_IRQ_MON    2
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MAPF_CLK_KHZ     10000
`define MAPF_LEAD_MS     300
`define MAPF_TAIL_MS     500
`define MAPF_FAST_PER_MS 1000
`define MAPF_FAST_ON_MS  500
`define MAPF_SLOW_PER_MS 3000
`define MAPF_SLOW_ON_MS  300
`endif

// [rtl/mapf_pkg.sv]
// Types shared by the auxiliary pad block
package mapf_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mapf_apb_req_s;
  typedef enum logic [3:0] {
    MAPF_LAMP_OFF  = 4'b0001,
    MAPF_LAMP_FAST = 4'b0010,
    MAPF_LAMP_SLOW = 4'b0100,
    MAPF_LAMP_ON   = 4'b1000
  } mapf_lamp_e;
  typedef logic [24:0] mapf_cnt_t;
  typedef logic [1:0]  mapf_mode_t;
endpackage

// [testbench/mapf_host_model.sv]
// Host-side model: pad wiring with pull-up, floating pads, lamp transistor
`timescale 1ns/10ps
module mapf_host_model (
  input  wire logic       mclk,     // Module clock
  input  wire logic [3:0] pad_out,  // Device drive value
  input  wire logic [3:0] pad_oe,   // Device drive enable
  input  wire logic [3:0] host_drv, // Host drive value
  input  wire logic [3:0] host_en,  // Host drive enable
  input  wire logic       lamp_pin, // Lamp pin from device
  output logic [3:0]      pad_in,   // Resolved pad levels
  output logic            lamp_lit  // Lamp state behind transistor
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  logic float_reg;
  initial float_reg = 1'b0;
  // Undriven pads without a resistor wander every cycle
  always @(posedge mclk) float_reg <= ~float_reg;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (pad_oe[k])
        pad_in[k] = pad_out[k];
      else if (host_en[k])
        pad_in[k] = host_drv[k];
      else if (k == 0)
        pad_in[k] = 1'b1;
      else
        pad_in[k] = float_reg;
    end
  end
  assign lamp_lit = ~lamp_pin;
endmodule

// [testbench/module_aux_pin_functions_test.sv]
// Self-checking testbench of the auxiliary pad block
`timescale 1ns/10ps
`include "mapf_consts.svh"
module module_aux_pin_functions_test;
  import mapf_pkg::*;
  localparam int LEAD = 20;
  localparam int TAIL = 30;
  logic          mclk, rst, pready, pslverr, tx_enable, status_lamp_pin, irq, lamp_lit;
  logic          tx_burst, call_active, dev_on, net_registered, shutting_down;
  logic          alarm_fire, tone_on, err;
  mapf_apb_req_s apb_req;
  logic [31:0]   prdata, rd;
  logic [3:0]    pad_in, pad_out, pad_oe, host_drv, host_en;
  int            failures, total_checks, k, j;
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  mapf_top #(.LEAD_CYC(LEAD), .TAIL_CYC(TAIL), .FAST_PER_CYC(40), .FAST_ON_CYC(20),
    .SLOW_PER_CYC(60), .SLOW_ON_CYC(6)) uut (.mclk(mclk), .rst(rst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .tx_burst(tx_burst), .call_active(call_active),
    .dev_on(dev_on), .net_registered(net_registered), .shutting_down(shutting_down),
    .alarm_fire(alarm_fire), .tone_on(tone_on), .tx_enable(tx_enable),
    .status_lamp_pin(status_lamp_pin), .irq(irq));
  mapf_host_model host (.mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .host_drv(host_drv), .host_en(host_en), .lamp_pin(status_lamp_pin),
    .pad_in(pad_in), .lamp_lit(lamp_lit));
  always #50 mclk = ~mclk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timeout();
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One APB transfer, released only after pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) timeout();
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_pad(input int b, input logic v);
    k = 0;
    while (pad_out[b] !== v && k < 200) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 200) timeout();
  endtask
  task automatic lamp_count(input int per);
    j = 0;
    repeat (per) begin
      @(posedge mclk);
      if (lamp_lit === 1'b1) j++;
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 0; rst = 1; apb_req = '0; host_drv = 4'h0; host_en = 4'h0;
    tx_burst = 0; call_active = 0; dev_on = 0; net_registered = 0;
    shutting_down = 0; alarm_fire = 0; tone_on = 0; failures = 0; total_checks = 0;
    cyc(3);
    chk(pad_oe, 4'h0);
    chk(status_lamp_pin, 1'b1);
    rst <= 0;
    cyc(1);
    xfer(0, `MAPF_OFS_MODE, 0); chk(rd, 32'h0000_0000);
    xfer(0, 8'h40, 0); chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    xfer(1, `MAPF_OFS_MODE, 32'h55); xfer(1, `MAPF_OFS_OUT, 32'hA);
    cyc(1); chk({pad_oe, pad_out}, 8'hFA);
    xfer(1, `MAPF_OFS_OUT, 32'h5); cyc(1); chk(pad_out, 4'h5);
    xfer(1, `MAPF_OFS_MODE, 32'h0); cyc(1); chk(pad_oe, 4'h0);
    host_en <= 4'hF; host_drv <= 4'h6; cyc(2);
    xfer(0, `MAPF_OFS_IN, 0); chk(rd, 32'h6);
    host_drv <= 4'h9; cyc(2);
    xfer(0, `MAPF_OFS_IN, 0); chk(rd, 32'h9);
    host_en <= 4'h0; host_drv <= 4'h0;
    xfer(1, `MAPF_OFS_ISTS, 32'h7); xfer(1, `MAPF_OFS_MODE, 32'h02);
    host_en[0] <= 1'b1; cyc(3); chk(tx_enable, 1'b0);
    xfer(0, `MAPF_OFS_ISTS, 0); chk(rd[`MAPF_IRQ_INH], 1'b1);
    host_en[0] <= 1'b0; cyc(3); chk(tx_enable, 1'b1);
    xfer(1, `MAPF_OFS_MODE, 32'h08); xfer(1, `MAPF_OFS_MON, 32'h1);
    tx_burst <= 1; wait_pad(1, 1); chk(k <= 3, 1'b1);
    cyc(4); chk(pad_out[1], 1'b1);
    tx_burst <= 0; wait_pad(1, 0); chk(k <= 3, 1'b1);
    xfer(1, `MAPF_OFS_MON, 32'h0);
    call_active <= 1; tx_burst <= 1; wait_pad(1, 1);
    chk(tx_enable, 1'b0);
    j = k;
    while (tx_enable !== 1'b1 && j < 200) begin
      @(posedge mclk);
      j++;
    end
    chk(j >= LEAD && j <= LEAD + 3, 1'b1);
    cyc(5); chk(pad_out[1], 1'b1);
    call_active <= 0; tx_burst <= 0; wait_pad(1, 0);
    chk(k >= TAIL && k <= 2 * TAIL, 1'b1);
    xfer(1, `MAPF_OFS_ISTS, 32'h7); xfer(1, `MAPF_OFS_IMSK, 32'h1);
    xfer(1, `MAPF_OFS_MODE, 32'h20);
    alarm_fire <= 1; cyc(1); alarm_fire <= 0; cyc(8);
    chk({pad_oe[2], pad_out[2], irq}, 3'b111);
    xfer(1, `MAPF_OFS_CMD, 32'h1); cyc(2); chk(pad_out[2], 1'b0);
    xfer(1, `MAPF_OFS_ISTS, 32'h1); cyc(2); chk(irq, 1'b0);
    xfer(1, `MAPF_OFS_IMSK, 32'h0);
    alarm_fire <= 1; cyc(1); alarm_fire <= 0; cyc(4); chk(irq, 1'b0);
    xfer(1, `MAPF_OFS_MODE, 32'h80); xfer(1, `MAPF_OFS_TONE, 32'h3); tone_on <= 1;
    wait_pad(3, 1); wait_pad(3, 0); chk(k, 3);
    wait_pad(3, 1); chk(k, 3);
    tone_on <= 0;
    lamp_count(60); chk(j, 0);
    dev_on <= 1; cyc(4); lamp_count(40); chk(j, 20);
    net_registered <= 1; shutting_down <= 1; cyc(4); lamp_count(40); chk(j, 20);
    shutting_down <= 0; cyc(4); lamp_count(60); chk(j, 6);
    xfer(0, `MAPF_OFS_STAT, 0); chk(rd[6:3], MAPF_LAMP_SLOW);
    call_active <= 1; cyc(4); lamp_count(60); chk(j, 60);
    chk(status_lamp_pin, 1'b0);
    tally_and_finish();
  end
endmodule
